// ==== sbs_serial_break_sync_tx.sv ====
// break generator, break receiver and synchronous master transmitter with Avalon-MM registers
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sbs_serial_break_sync_tx
  import sbs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              data_pin_i,
  output logic                   data_pin_o,
  output logic                   data_pin_oe,
  input  wire logic              clock_pin_i,
  output logic                   clock_pin_o,
  output logic                   clock_pin_oe
);
  function automatic logic [15:0] sbs_half(input logic [15:0] d);
    sbs_half = (d > 16'h0001) ? (d >> 1) : 16'h0001;
  endfunction : sbs_half

  function automatic logic [15:0] sbs_reload(input logic [15:0] p);
    sbs_reload = (p > 16'h0000) ? (p - 16'h0001) : 16'h0000;
  endfunction : sbs_reload

  logic [1:0] rst_ff_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rst_ff_q <= 2'b00;
    else rst_ff_q <= {rst_ff_q[0], 1'b1};
  end
  assign rst_n = rst_ff_q[1];

  // bus slave: request seen with waitrequest high, answered next cycle
  logic              wait_q;
  logic [31:0]       rdata_q;
  logic [ADDR_W-1:0] addr;
  logic              acc_rd;
  logic              acc_wr;
  assign addr   = avs_address;
  assign acc_wr = avs_write && !wait_q;
  assign acc_rd = avs_read && !wait_q;

  sbs_ctrl_type     ctl_q;
  logic [15:0]      div_q;
  logic [7:0]       hold_q;
  logic             hold_full_q;
  logic             hold_brk_q;
  sbs_tx_state_type tx_st_q;
  logic [13:0]      sh_q;
  logic [3:0]       cnt_q;
  logic [15:0]      tcnt_q;
  logic             frame_brk_q;
  logic             phase_q;
  logic             line_q;
  logic             sclk_q;
  sbs_rx_state_type rx_st_q;
  logic [15:0]      rcnt_q;
  logic [3:0]       rbits_q;
  logic [7:0]       rsh_q;
  logic [7:0]       rx_data_q;
  logic             framing_error_flag_q;
  logic             rcf_q;
  logic [1:0]       rx_ff_q;
  logic             rx_prev_q;
  sbs_pins_type     pins_q;

  logic rx_s;
  logic rx_fall;
  logic rx_rise;
  assign rx_s    = rx_ff_q[1];
  assign rx_fall = rx_prev_q && !rx_s;
  assign rx_rise = !rx_prev_q && rx_s;

  logic sync_master;
  logic sync_tx;
  logic tx_busy;
  logic brk_inflight;
  logic ld;
  logic ttick;
  logic tx_end;
  logic brk_done;
  logic [15:0] tper;
  assign sync_master  = ctl_q.sync && ctl_q.clock_source_master && ctl_q.port_enable;
  assign sync_tx      = sync_master && !ctl_q.single_receive_enable && !ctl_q.continuous_receive_enable;
  assign tx_busy      = (tx_st_q != TX_IDLE);
  assign brk_inflight = (tx_busy && frame_brk_q) || (hold_full_q && hold_brk_q);
  assign ld           = !tx_busy && hold_full_q && ctl_q.transmit_enable && ctl_q.port_enable;
  assign ttick        = tx_busy && (tcnt_q == 16'h0000);
  assign tper         = ctl_q.sync ? sbs_half(div_q) : div_q;
  assign tx_end       = ttick && (cnt_q == 4'h1)
                        && ((tx_st_q == TX_ASYNC) || !phase_q);
  assign brk_done     = tx_end && frame_brk_q;

  logic [31:0] rd_mux;
  assign rd_mux =
    (addr == OFS_TX_CTRL) ? {26'h0, !hold_full_q, !tx_busy, ctl_q.clock_source_master, ctl_q.sync,
                             ctl_q.brk, ctl_q.transmit_enable} :
    (addr == OFS_RX_CTRL) ? {26'h0, (rx_st_q == RX_IDLE), rcf_q, framing_error_flag_q, ctl_q.continuous_receive_enable,
                             ctl_q.single_receive_enable, ctl_q.port_enable} :
    (addr == OFS_RATE)    ? {29'h0, ctl_q.pol, ctl_q.abd, ctl_q.wake_on_low_enable} :
    (addr == OFS_RX_DATA) ? {24'h0, rx_data_q} :
    (addr == OFS_DIVISOR) ? {16'h0, div_q} : BUS_ZERO;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= BUS_ZERO;
    end else begin
      wait_q  <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) rdata_q <= rd_mux;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

  // control registers; hardware clears break request and wake enable
  logic wr_tx;
  logic wr_rx;
  logic wr_rt;
  logic wr_dat;
  assign wr_tx  = acc_wr && (addr == OFS_TX_CTRL);
  assign wr_rx  = acc_wr && (addr == OFS_RX_CTRL);
  assign wr_rt  = acc_wr && (addr == OFS_RATE);
  assign wr_dat = acc_wr && (addr == OFS_TX_DATA);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= '0;
      div_q <= DIV_RESET;
    end else begin
      if (wr_tx) begin
        ctl_q.transmit_enable <= avs_writedata[TXC_TRANSMIT_ENABLE];
        ctl_q.sync <= avs_writedata[TXC_SYNC];
        ctl_q.clock_source_master <= avs_writedata[TXC_CLOCK_SOURCE_MASTER];
      end
      if (wr_tx) ctl_q.brk <= avs_writedata[TXC_BRK];
      else if (brk_done) ctl_q.brk <= 1'b0;
      if (wr_rx) begin
        ctl_q.port_enable <= avs_writedata[RXC_PORT_ENABLE];
        ctl_q.single_receive_enable <= avs_writedata[RXC_SINGLE_RECEIVE_ENABLE];
        ctl_q.continuous_receive_enable <= avs_writedata[RXC_CONTINUOUS_RECEIVE_ENABLE];
      end
      if (ctl_q.wake_on_low_enable && rx_rise) ctl_q.wake_on_low_enable <= 1'b0;
      else if (wr_rt) ctl_q.wake_on_low_enable <= avs_writedata[RTC_WUE];
      if (wr_rt) begin
        ctl_q.abd <= avs_writedata[RTC_ABD];
        ctl_q.pol <= avs_writedata[RTC_POL];
      end
      if (acc_wr && (addr == OFS_DIVISOR)) div_q <= avs_writedata[15:0];
    end
  end

  // holding register: a write waits here until the shift register frees up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q      <= 8'h00;
      hold_full_q <= 1'b0;
      hold_brk_q  <= 1'b0;
    end else if (wr_dat) begin
      hold_q      <= avs_writedata[7:0];
      hold_full_q <= 1'b1;
      hold_brk_q  <= ctl_q.brk && ctl_q.transmit_enable && !brk_inflight;
    end else if (ld) begin
      hold_full_q <= 1'b0;
    end
  end

  // transmit shifter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q     <= TX_IDLE;
      sh_q        <= 14'h0000;
      cnt_q       <= 4'h0;
      tcnt_q      <= 16'h0000;
      frame_brk_q <= 1'b0;
      phase_q     <= 1'b0;
      line_q      <= 1'b1;
      sclk_q      <= 1'b0;
    end else if (ld) begin
      tcnt_q <= sbs_reload(tper);
      if (ctl_q.sync) begin
        tx_st_q     <= TX_SYNC;
        sh_q        <= {6'h00, hold_q};
        cnt_q       <= DATA_BITS;
        frame_brk_q <= 1'b0;
        phase_q     <= 1'b1;
        line_q      <= hold_q[0];
        sclk_q      <= !ctl_q.pol;
      end else begin
        tx_st_q     <= TX_ASYNC;
        sh_q        <= hold_brk_q ? BREAK_FRAME : {4'h0, 1'b1, hold_q, 1'b0};
        cnt_q       <= hold_brk_q ? BREAK_FRAME_BITS : ASYNC_FRAME_BITS;
        frame_brk_q <= hold_brk_q;
        line_q      <= 1'b0;
      end
    end else if (!tx_busy) begin
      line_q <= ctl_q.sync ? line_q : 1'b1;
      sclk_q <= ctl_q.pol;
    end else if (!ttick) begin
      tcnt_q <= tcnt_q - 16'h0001;
    end else begin
      tcnt_q <= sbs_reload(tper);
      if (tx_st_q == TX_ASYNC) begin
        sh_q   <= {1'b0, sh_q[13:1]};
        line_q <= sh_q[1];
        cnt_q  <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          tx_st_q <= TX_IDLE;
          line_q  <= 1'b1;
        end
      end else if (phase_q) begin
        sclk_q  <= ctl_q.pol;
        phase_q <= 1'b0;
      end else if (cnt_q == 4'h1) begin
        tx_st_q <= TX_IDLE;
      end else begin
        sclk_q  <= !ctl_q.pol;
        sh_q    <= {1'b0, sh_q[13:1]};
        line_q  <= sh_q[1];
        cnt_q   <= cnt_q - 4'h1;
        phase_q <= 1'b1;
      end
    end
  end

  // receiver: line passes two flops first; idle while wake is armed
  logic rx_en;
  logic rtick;
  assign rx_en = ctl_q.port_enable && !ctl_q.sync && ctl_q.continuous_receive_enable && !ctl_q.wake_on_low_enable;
  assign rtick = (rcnt_q == 16'h0000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ff_q   <= 2'b11;
      rx_prev_q <= 1'b1;
    end else begin
      rx_ff_q   <= {rx_ff_q[0], data_pin_i};
      rx_prev_q <= rx_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= RX_IDLE;
      rcnt_q  <= 16'h0000;
      rbits_q <= 4'h0;
      rsh_q   <= 8'h00;
    end else if (!rx_en) begin
      rx_st_q <= RX_IDLE;
    end else if (rx_st_q == RX_IDLE) begin
      if (rx_fall) begin
        rx_st_q <= RX_START;
        rcnt_q  <= sbs_reload(sbs_half(div_q));
      end
    end else if (!rtick) begin
      rcnt_q <= rcnt_q - 16'h0001;
    end else begin
      rcnt_q <= sbs_reload(div_q);
      case (rx_st_q)
        RX_START: begin
          rx_st_q <= rx_s ? RX_IDLE : RX_DATA;
          rbits_q <= DATA_BITS;
        end
        RX_DATA: begin
          rsh_q   <= {rx_s, rsh_q[7:1]};
          rbits_q <= rbits_q - 4'h1;
          if (rbits_q == 4'h1) rx_st_q <= RX_STOP;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  logic rx_done;
  logic wake_evt;
  assign rx_done  = rx_en && (rx_st_q == RX_STOP) && rtick;
  assign wake_evt = ctl_q.wake_on_low_enable && rx_fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_q <= 8'h00;
      framing_error_flag_q    <= 1'b0;
      rcf_q     <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_data_q <= rsh_q;
        framing_error_flag_q    <= !rx_s;
      end
      if (rx_done || wake_evt) rcf_q <= 1'b1;
      else if (acc_rd && (addr == OFS_RX_DATA)) rcf_q <= 1'b0;
    end
  end

  // pins: async sends on the clock pin, sync master drives the clock pin, and the data pin too unless a receive enable is set
  sbs_pins_type pins_d;
  assign pins_d.clk_o   = ctl_q.sync ? sclk_q : line_q;
  assign pins_d.clk_oe  = ctl_q.port_enable && (!ctl_q.sync || ctl_q.clock_source_master);
  assign pins_d.data_o  = line_q;
  assign pins_d.data_oe = sync_tx;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pins_q <= '0;
    else pins_q <= pins_d;
  end
  assign data_pin_o   = pins_q.data_o;
  assign data_pin_oe  = pins_q.data_oe;
  assign clock_pin_o  = pins_q.clk_o;
  assign clock_pin_oe = pins_q.clk_oe;

  a_break_zeros: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_st_q == TX_ASYNC) && frame_brk_q && (cnt_q > 4'h1) |-> !line_q)
    else $error("break frame line not low");
  a_break_load: assert property (@(posedge clk) disable iff (!rst_n)
    ld && hold_brk_q && !ctl_q.sync |=> (sh_q == BREAK_FRAME) && (cnt_q == BREAK_FRAME_BITS))
    else $error("break frame not loaded");
  a_break_clear: assert property (@(posedge clk) disable iff (!rst_n)
    brk_done && !wr_tx |=> !ctl_q.brk && !tx_busy)
    else $error("break request not cleared");
  a_hold_wait: assert property (@(posedge clk) disable iff (!rst_n)
    tx_busy && hold_full_q && !wr_dat |=> hold_full_q)
    else $error("held char moved early");
  a_load_now: assert property (@(posedge clk) disable iff (!rst_n)
    ld && !wr_dat |=> tx_busy && !hold_full_q ##1 tx_busy)
    else $error("char not loaded at once");
  a_wake_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ctl_q.wake_on_low_enable |=> rx_st_q == RX_IDLE)
    else $error("receiver active in wake mode");
  a_wake_flag: assert property (@(posedge clk) disable iff (!rst_n)
    wake_evt |=> rcf_q)
    else $error("wake edge not flagged");
  a_rx_break: assert property (@(posedge clk) disable iff (!rst_n)
    rx_done && (rsh_q == 8'h00) && !rx_s |=> framing_error_flag_q && rcf_q && (rx_data_q == 8'h00))
    else $error("received break not reported");
  a_lead_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_st_q == TX_SYNC) && !(ttick && !phase_q) |=> $stable(line_q))
    else $error("sync data changed off leading edge");
  a_clk_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !tx_busy && !ld && ctl_q.sync
    |=> ##1 (!$past(ctl_q.sync) || (pins_q.clk_o == $past(ctl_q.pol, 2))))
    else $error("clock idle level wrong");
  a_sync_oe: assert property (@(posedge clk) disable iff (!rst_n)
    sync_tx |=> pins_q.data_oe && pins_q.clk_oe)
    else $error("sync drivers not enabled");
  a_txbe_status: assert property (@(posedge clk) disable iff (!rst_n)
    avs_read && wait_q && (addr == OFS_TX_CTRL) |=> rdata_q[TXC_TXBE] == !$past(hold_full_q))
    else $error("buffer empty status wrong");
  a_tx_shift_empty_status: assert property (@(posedge clk) disable iff (!rst_n)
    avs_read && wait_q && (addr == OFS_TX_CTRL) |=> rdata_q[TXC_TX_SHIFT_EMPTY] == ($past(tx_st_q) == TX_IDLE))
    else $error("shift empty status wrong");
  a_break_stop: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_st_q == TX_ASYNC) && frame_brk_q && (cnt_q == 4'h1) |-> line_q)
    else $error("break stop bit not high");
  a_sync_first: assert property (@(posedge clk) disable iff (!rst_n)
    ld && ctl_q.sync |=> (line_q == $past(hold_q[0])) && (cnt_q == DATA_BITS))
    else $error("sync char not started with bit zero");
  a_trail_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_st_q == TX_SYNC) && ttick && phase_q |=> sclk_q == $past(ctl_q.pol))
    else $error("trailing edge not to idle level");
  a_wake_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ctl_q.wake_on_low_enable && rx_rise |=> !ctl_q.wake_on_low_enable)
    else $error("wake enable not cleared");
  a_rx_clear: assert property (@(posedge clk) disable iff (!rst_n)
    acc_rd && (addr == OFS_RX_DATA) && !rx_done && !wake_evt |=> !rcf_q)
    else $error("char flag not cleared by read");
  a_rx_dir: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_tx |=> !pins_q.data_oe)
    else $error("data driver on outside sync transmit");
  a_clock_drv: assert property (@(posedge clk) disable iff (!rst_n)
    sync_master |=> pins_q.clk_oe)
    else $error("master clock driver not enabled");
endmodule : sbs_serial_break_sync_tx

// ==== sbs_pkg.sv ====
// constants, types and register map of the serial break and sync master transmitter
package sbs_pkg;
  localparam int          ADDR_W       = 3;
  localparam logic [2:0]  OFS_TX_CTRL  = 3'h0;
  localparam logic [2:0]  OFS_RX_CTRL  = 3'h1;
  localparam logic [2:0]  OFS_RATE     = 3'h2;
  localparam logic [2:0]  OFS_TX_DATA  = 3'h3;
  localparam logic [2:0]  OFS_RX_DATA  = 3'h4;
  localparam logic [2:0]  OFS_DIVISOR  = 3'h5;
  // transmit_control_reg fields
  localparam int TXC_TRANSMIT_ENABLE = 0;
  localparam int TXC_BRK  = 1;
  localparam int TXC_SYNC = 2;
  localparam int TXC_CLOCK_SOURCE_MASTER = 3;
  localparam int TXC_TX_SHIFT_EMPTY = 4;
  localparam int TXC_TXBE = 5;
  // receive_control_reg fields
  localparam int RXC_PORT_ENABLE = 0;
  localparam int RXC_SINGLE_RECEIVE_ENABLE = 1;
  localparam int RXC_CONTINUOUS_RECEIVE_ENABLE = 2;
  localparam int RXC_FRAMING_ERROR_FLAG = 3;
  localparam int RXC_RCF  = 4;
  localparam int RXC_IDLE = 5;
  // rate_control_reg fields
  localparam int RTC_WUE  = 0;
  localparam int RTC_ABD  = 1;
  localparam int RTC_POL  = 2;
  localparam logic [15:0] DIV_RESET        = 16'h0020;
  localparam logic [3:0]  DATA_BITS        = 4'h8;
  localparam logic [3:0]  ASYNC_FRAME_BITS = 4'hA;
  localparam logic [3:0]  BREAK_ZERO_BITS  = 4'hC;
  localparam logic [3:0]  BREAK_FRAME_BITS = 4'hE;
  localparam logic [13:0] BREAK_FRAME      = 14'h2000;
  localparam logic [31:0] BUS_ZERO         = 32'h0000_0000;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_ASYNC = 2'b01,
    TX_SYNC  = 2'b10
  } sbs_tx_state_type;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } sbs_rx_state_type;
  typedef struct packed {
    logic data_o;
    logic data_oe;
    logic clk_o;
    logic clk_oe;
  } sbs_pins_type;
  typedef struct packed {
    logic transmit_enable;
    logic brk;
    logic sync;
    logic clock_source_master;
    logic port_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic wake_on_low_enable;
    logic abd;
    logic pol;
  } sbs_ctrl_type;
endpackage : sbs_pkg

// ==== sbs_peer_model.sv ====
// remote serial peer: async frame sender and receiver, sync slave capture
`timescale 1ns/1ps
module sbs_peer_model (
  input  wire logic clk,
  input  wire logic line_i,
  input  wire logic dat_i,
  input  wire logic sync_i,
  input  wire logic pol_i,
  output logic      rx_o
);
  localparam int BIT_CYC = 32;
  logic [7:0]  rx_byte   = 8'h00;
  logic [15:0] sync_word = 16'h0000;
  int          low_bits  = 0;
  int          frames    = 0;
  int          edges     = 0;
  initial rx_o = 1'b1;
  // samples mid-bit; low_bits counts the low run from the start bit on
  always begin : async_rx
    int   i;
    logic hi;
    @(negedge line_i);
    if (!sync_i) begin
      repeat (BIT_CYC / 2) @(posedge clk);
      low_bits = 1;
      hi = 1'b0;
      i = 0;
      do begin
        repeat (BIT_CYC) @(posedge clk);
        if (i < 8) rx_byte[i] = line_i;
        hi = hi | line_i;
        if (!hi) low_bits++;
        i++;
      end while (i < 9 || !line_i);
      frames++;
    end
  end
  // the trailing edge returns the clock to idle; data is taken there
  always @(line_i) begin
    if (sync_i && line_i === pol_i) begin
      sync_word = {dat_i, sync_word[15:1]};
      edges++;
    end
  end
  // start bit, n bits of b (zeros past bit 7), stop bit; line idles high
  task automatic send(input logic [7:0] b, input int n);
    logic [15:0] w;
    w = {8'h00, b};
    rx_o <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rx_o <= w[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rx_o <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
  endtask : send
endmodule : sbs_peer_model

// ==== tb_top.sv ====
// self-checking bench: break, header, break receive, wake and sync master transmit
`timescale 1ns/1ps
module tb_top;
  import sbs_pkg::*;
  logic              clk           = 1'b0;
  logic              rstn          = 1'b0;
  logic [ADDR_W-1:0] avs_address   = '0;
  logic              avs_read      = 1'b0;
  logic              avs_write     = 1'b0;
  logic [31:0]       avs_writedata = BUS_ZERO;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              data_pin_o;
  logic              data_pin_oe;
  logic              clock_pin_o;
  logic              clock_pin_oe;
  logic              peer_rx;
  logic              sync_mode     = 1'b0;
  logic              pol           = 1'b0;
  logic [31:0]       rd;
  int                fail_count    = 0;
  int                checks        = 0;
  wire               data_line     = data_pin_oe ? data_pin_o : peer_rx;
  always #2.5 clk = ~clk;
  sbs_serial_break_sync_tx u_sbs_serial_break_sync_tx (
    .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .data_pin_i(data_line), .data_pin_o(data_pin_o),
    .data_pin_oe(data_pin_oe), .clock_pin_i(clock_pin_o), .clock_pin_o(clock_pin_o),
    .clock_pin_oe(clock_pin_oe)
  );
  sbs_peer_model u_sbs_peer_model (
    .clk(clk), .line_i(clock_pin_o), .dat_i(data_line), .sync_i(sync_mode),
    .pol_i(pol), .rx_o(peer_rx)
  );
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic [2:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) chk("bus answer", 32'h1, 32'h0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic poll(input logic [2:0] a, input int b, input logic v);
    int n;
    n = 0;
    xfer(a, 1'b0, BUS_ZERO);
    while (rd[b] !== v && n < 400) begin
      xfer(a, 1'b0, BUS_ZERO);
      n++;
    end
    chk("poll bit", 32'(rd[b]), 32'(v));
  endtask : poll
  task automatic wait_frame(input int n);
    int k;
    k = 0;
    while (u_sbs_peer_model.frames < n && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) chk("frame wait", 32'h1, 32'h0);
  endtask : wait_frame
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin : watchdog
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  initial begin : main
    int f;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // let the line settle after reset before frames are counted
    repeat (400) @(posedge clk);
    xfer(OFS_TX_CTRL, 1'b0, BUS_ZERO);
    chk("tx ctrl reset", rd, 32'h0000_0030);
    xfer(OFS_DIVISOR, 1'b0, BUS_ZERO);
    chk("divisor reset", rd, {16'h0000, DIV_RESET});
    xfer(OFS_TX_DATA, 1'b0, BUS_ZERO);
    chk("tx data read", rd, BUS_ZERO);
    for (int a = 6; a < 8; a++) begin
      xfer(3'(a), 1'b1, 32'hFFFF_FFFF);
      xfer(3'(a), 1'b0, BUS_ZERO);
      chk("unmapped", rd, BUS_ZERO);
    end
    $display("test registers done");
    xfer(OFS_RX_CTRL, 1'b1, 32'h1);
    xfer(OFS_TX_CTRL, 1'b1, 32'h3);
    f = u_sbs_peer_model.frames;
    xfer(OFS_TX_DATA, 1'b1, 32'hFF);
    xfer(OFS_TX_DATA, 1'b1, 32'h55);
    xfer(OFS_TX_CTRL, 1'b0, BUS_ZERO);
    chk("break queued", rd, 32'h3);
    wait_frame(f + 1);
    chk("break low run", 32'(u_sbs_peer_model.low_bits), 32'd13);
    wait_frame(f + 2);
    chk("sync byte", 32'(u_sbs_peer_model.rx_byte), 32'h55);
    poll(OFS_TX_CTRL, TXC_TX_SHIFT_EMPTY, 1'b1);
    chk("tx ctrl after header", rd, 32'h31);
    $display("test break header done");
    xfer(OFS_RX_CTRL, 1'b1, 32'h5);
    u_sbs_peer_model.send(8'h00, 12);
    poll(OFS_RX_CTRL, RXC_RCF, 1'b1);
    chk("break flags", rd & 32'h1F, 32'h1D);
    xfer(OFS_RX_DATA, 1'b0, BUS_ZERO);
    chk("break data", rd, BUS_ZERO);
    xfer(OFS_RX_CTRL, 1'b0, BUS_ZERO);
    chk("flag cleared", 32'(rd[RXC_RCF]), 32'h0);
    $display("test break receive done");
    xfer(OFS_RATE, 1'b1, 32'h3);
    fork
      u_sbs_peer_model.send(8'h00, 12);
      begin
        repeat (200) @(posedge clk);
        xfer(OFS_RX_CTRL, 1'b0, BUS_ZERO);
        chk("wake flag", 32'(rd[RXC_RCF]), 32'h1);
        chk("wake idle", 32'(rd[RXC_IDLE]), 32'h1);
      end
    join
    xfer(OFS_RATE, 1'b0, BUS_ZERO);
    chk("wake cleared", rd, 32'h2);
    xfer(OFS_RX_DATA, 1'b0, BUS_ZERO);
    u_sbs_peer_model.send(8'hA5, 8);
    poll(OFS_RX_CTRL, RXC_RCF, 1'b1);
    xfer(OFS_RX_DATA, 1'b0, BUS_ZERO);
    chk("byte after wake", rd, 32'hA5);
    $display("test wake done");
    sync_mode = 1'b1;
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      xfer(OFS_RX_CTRL, 1'b1, 32'h1);
      xfer(OFS_RATE, 1'b1, {29'h0, pol, 2'b00});
      xfer(OFS_TX_CTRL, 1'b1, 32'hD);
      repeat (4) @(posedge clk);
      u_sbs_peer_model.edges = 0;
      chk("clock idle", 32'(clock_pin_o), 32'(pol));
      xfer(OFS_TX_DATA, 1'b1, 32'h3C);
      xfer(OFS_TX_DATA, 1'b1, 32'hC3);
      xfer(OFS_TX_CTRL, 1'b0, BUS_ZERO);
      chk("holding waits", rd, 32'hD);
      chk("drivers on", 32'({data_pin_oe, clock_pin_oe}), 32'h3);
      poll(OFS_TX_CTRL, TXC_TX_SHIFT_EMPTY, 1'b1);
      repeat (20) @(posedge clk);
      chk("sync word", 32'(u_sbs_peer_model.sync_word), 32'hC33C);
      chk("clock count", 32'(u_sbs_peer_model.edges), 32'd16);
      chk("clock idle after", 32'(clock_pin_o), 32'(pol));
    end
    xfer(OFS_RX_CTRL, 1'b1, 32'h5);
    repeat (4) @(posedge clk);
    chk("receive drivers", 32'({data_pin_oe, clock_pin_oe}), 32'h1);
    xfer(OFS_RX_CTRL, 1'b1, 32'h3);
    repeat (4) @(posedge clk);
    chk("single receive drivers", 32'({data_pin_oe, clock_pin_oe}), 32'h1);
    $display("test sync master done");
    print_verdict();
  end
endmodule : tb_top
